// File: ptm_timer.sv
// Purpose: 8-bit period timer with prescaler, postscaler and AHB-Lite registers
// Assumes: hclk is the oscillator clock at 20 MHz; single word transfers
// Notes:   Zero wait state slave, response always OKAY
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "ptm_map.svh"
module ptm_timer
  import ptm_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Time base and serial clock source
  output logic [7:0]       pwm_count,
  output logic [7:0]       pwm_period,
  output logic             ssp_match,
  // Interrupts
  output logic             irq,
  output logic             cpu_irq
);

  // Register state
  logic [7:0] count_q;
  logic [7:0] period_q;
  logic [6:0] ctrl_q;
  logic       flag_q;
  logic       irq_en_q;
  logic [1:0] gates_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [3:0] post_q;
  logic       match_q;
  logic       irq_q;
  logic       cpu_irq_q;
  logic [31:0] hrdata_q;
  logic       hready_q;

  // Bus pipeline
  logic       dp_wr_q;
  logic [7:0] dp_idx_q;
  logic       ap_valid;
  logic       ap_ok;
  logic [7:0] ap_idx;
  logic [7:0] rd_byte;
  logic       wr_count;
  logic       wr_ctrl;
  logic [7:0] wdat;

  // Timer internals
  logic       tick;
  logic [5:0] pre_cnt;
  logic       step;
  logic       match;
  logic       post_done;
  logic       scal_clr;
  logic       status_rd;
  logic [1:0] events;

  // Address phase decode
  assign ap_valid = hsel && hready && htrans[1];
  assign ap_ok    = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
  assign ap_idx   = haddr[9:2];

  // Data phase write strobes
  assign wdat     = hwdata[7:0];
  assign wr_count = dp_wr_q && (dp_idx_q == `PTM_IDX_COUNT);
  assign wr_ctrl  = dp_wr_q && (dp_idx_q == `PTM_IDX_CTRL);
  assign scal_clr = wr_count || wr_ctrl;

  // Capture address phase for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q  <= 1'b0;
      dp_idx_q <= 8'h00;
    end else begin
      dp_wr_q  <= ap_valid && hwrite && ap_ok;
      dp_idx_q <= ap_idx;
    end
  end

  // Read mux, unmapped reads return zero
  always_comb begin
    rd_byte = 8'h00;
    if (ap_ok) begin
      case (ap_idx)
        `PTM_IDX_FLAGS:   rd_byte = {6'h00, flag_q, 1'b0};
        `PTM_IDX_COUNT:   rd_byte = count_q;
        `PTM_IDX_CTRL:    rd_byte = {1'b0, ctrl_q};
        `PTM_IDX_ENABLES: rd_byte = {6'h00, irq_en_q, 1'b0};
        `PTM_IDX_PERIOD:  rd_byte = period_q;
        `PTM_IDX_GATES:   rd_byte = {6'h00, gates_q};
        `PTM_IDX_STATUS:  rd_byte = {6'h00, status_q};
        `PTM_IDX_MASK:    rd_byte = {6'h00, mask_q};
        default:          rd_byte = 8'h00;
      endcase
    end
  end

  // Read data and response registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
      hready_q <= 1'b1;
    end else begin
      hready_q <= 1'b1;
      if (ap_valid && !hwrite) begin
        hrdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  assign status_rd = ap_valid && !hwrite && ap_ok && (ap_idx == `PTM_IDX_STATUS);

  // Prescaler with instruction clock divider
  ptm_prescaler u_presc (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clear     (scal_clr),
    .run       (ctrl_q[`PTM_RUN_BIT]),
    .presc_sel (ptm_presc_e'(ctrl_q[`PTM_PRE_MSB:0])),
    .tick      (tick),
    .cnt       (pre_cnt)
  );

  // Counter step and period match
  // A counter or control write drops a coinciding tick, so the count does not step
  assign step      = tick && ctrl_q[`PTM_RUN_BIT] && !scal_clr;
  assign match     = step && (count_q == period_q);
  assign post_done = match && (post_q == ctrl_q[`PTM_POST_MSB:`PTM_POST_LSB]);

  // Counter: software write wins over the step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `PTM_RST_COUNT;
    end else if (wr_count) begin
      count_q <= wdat;
    end else if (match) begin
      count_q <= 8'h00;
    end else if (step) begin
      count_q <= count_q + 8'h01;
    end
  end

  // Period register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_q <= `PTM_RST_PERIOD;
    end else if (dp_wr_q && dp_idx_q == `PTM_IDX_PERIOD) begin
      period_q <= wdat;
    end
  end

  // Control register, bit 7 not stored; count untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `PTM_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= wdat[6:0];
    end
  end

  // Postscaler: ratio is field plus one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_q <= 4'h0;
    end else if (scal_clr) begin
      post_q <= 4'h0;
    end else if (post_done) begin
      post_q <= 4'h0;
    end else if (match) begin
      post_q <= post_q + 4'h1;
    end
  end

  // Period match flag, hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else if (post_done) begin
      flag_q <= 1'b1;
    end else if (dp_wr_q && dp_idx_q == `PTM_IDX_FLAGS) begin
      flag_q <= wdat[`PTM_FLAG_BIT];
    end
  end

  // Enables, gates and mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= 1'b0;
      gates_q  <= 2'b00;
      mask_q   <= 2'b00;
    end else if (dp_wr_q) begin
      if (dp_idx_q == `PTM_IDX_ENABLES) begin
        irq_en_q <= wdat[`PTM_FLAG_BIT];
      end
      if (dp_idx_q == `PTM_IDX_GATES) begin
        gates_q <= wdat[1:0];
      end
      if (dp_idx_q == `PTM_IDX_MASK) begin
        mask_q <= wdat[1:0];
      end
    end
  end

  // Sticky event status, cleared by read, new event wins
  assign events = {match, post_done};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 2'b00;
    end else if (status_rd) begin
      status_q <= events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_q   <= 1'b0;
      irq_q     <= 1'b0;
      cpu_irq_q <= 1'b0;
    end else begin
      match_q   <= match;
      irq_q     <= |(status_q & mask_q);
      cpu_irq_q <= flag_q && irq_en_q && gates_q[`PTM_GATE_PERI]
                   && gates_q[`PTM_GATE_GLOB];
    end
  end

  assign hrdata     = hrdata_q;
  assign hreadyout  = hready_q;
  assign hresp      = 1'b0;
  assign pwm_count  = count_q;
  assign pwm_period = period_q;
  assign ssp_match  = match_q;
  assign irq        = irq_q;
  assign cpu_irq    = cpu_irq_q;

  // Checks
  sequence seq_ctrl_wr;
    ap_valid && hwrite && ap_ok && (ap_idx == `PTM_IDX_CTRL) ##1 wr_ctrl;
  endsequence

  sequence seq_ctrl_rd;
    ap_valid && !hwrite && ap_ok && (ap_idx == `PTM_IDX_CTRL);
  endsequence

  AST_PRESC_TERM: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick |-> (pre_cnt == `PTM_PRE_TERM_1 && ctrl_q[1:0] == 2'b00)
          || (pre_cnt == `PTM_PRE_TERM_4 && ctrl_q[1:0] == 2'b01)
          || (pre_cnt == `PTM_PRE_TERM_16 && ctrl_q[1])
  ) else $error("Prescaler tick at wrong count");

  AST_WRAP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    match |=> count_q == 8'h00
  ) else $error("Counter did not wrap on period match");

  AST_INC: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step && !match |=> count_q == $past(count_q) + 8'h01
  ) else $error("Counter did not increment");

  AST_PERIOD_RST: assert property (
    @(posedge hclk) $rose(hresetn) |-> period_q == `PTM_RST_PERIOD
  ) else $error("Period not all ones after reset");

  AST_COUNT_WR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_count |=> count_q == $past(wdat)
  ) else $error("Counter write lost");

  AST_FLAG_SET: assert property (
    @(posedge hclk) disable iff (!hresetn)
    post_done |=> flag_q
  ) else $error("Postscaler completion did not set flag");

  AST_POST_STEP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    match && !post_done && !scal_clr |=> post_q == $past(post_q) + 4'h1
  ) else $error("Postscaler did not advance");

  AST_STOPPED: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ctrl_q[`PTM_RUN_BIT] && !wr_count |=> $stable(count_q)
  ) else $error("Counter moved while stopped");

  AST_SCAL_CLR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    seq_ctrl_wr |=> pre_cnt == 6'h00 && post_q == 4'h0
  ) else $error("Control write did not clear scalers");

  AST_CTRL_KEEP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    seq_ctrl_wr |=> count_q == $past(count_q)
  ) else $error("Control write changed counter");

  AST_SSP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    match |=> ssp_match ##1 !ssp_match
  ) else $error("Serial clock match not one cycle");

  AST_BIT7: assert property (
    @(posedge hclk) disable iff (!hresetn)
    seq_ctrl_rd |=> hrdata[7] == 1'b0
  ) else $error("Control bit 7 read as one");

  AST_CPU_IRQ: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cpu_irq |-> $past(flag_q) && $past(irq_en_q) && $past(gates_q) == 2'b11
  ) else $error("Processor interrupt without all enables");

  AST_CPU_IRQ_ON: assert property (
    @(posedge hclk) disable iff (!hresetn)
    flag_q && irq_en_q && gates_q == 2'b11 |=> cpu_irq
  ) else $error("Processor interrupt missing with all enables");

  AST_CNT_WR_CLR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_count |=> pre_cnt == 6'h00 && post_q == 4'h0
  ) else $error("Counter write did not clear scalers");

endmodule

// File: ptm_map.svh
// Purpose: Register indices, field positions, reset values and counts
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// Register indices
`define PTM_IDX_FLAGS    8'h0C
`define PTM_IDX_COUNT    8'h11
`define PTM_IDX_CTRL     8'h12
`define PTM_IDX_ENABLES  8'h8C
`define PTM_IDX_PERIOD   8'h92
`define PTM_IDX_GATES    8'hA0
`define PTM_IDX_STATUS   8'hA1
`define PTM_IDX_MASK     8'hA2

// Field positions
`define PTM_FLAG_BIT     1
`define PTM_RUN_BIT      2
`define PTM_POST_LSB     3
`define PTM_POST_MSB     6
`define PTM_PRE_MSB      1
`define PTM_GATE_PERI    0
`define PTM_GATE_GLOB    1
`define PTM_EV_POST      0
`define PTM_EV_RAW       1

// Reset values
`define PTM_RST_COUNT    8'h00
`define PTM_RST_PERIOD   8'hFF
`define PTM_RST_CTRL     7'h00
`define PTM_CTRL_MASK    8'h7F

// Terminal counts: four oscillator clocks per instruction cycle times ratio
`define PTM_PRE_TERM_1   6'h03
`define PTM_PRE_TERM_4   6'h0F
`define PTM_PRE_TERM_16  6'h3F

`endif

// File: ptm_pkg.sv
// Purpose: Types shared by the period timer files
// Assumes: Nothing beyond the register map header
// Notes:   Constants live in ptm_map.svh
package ptm_pkg;

  // Prescale select codes
  typedef enum logic [1:0] {
    PTM_PRESC_1   = 2'b00,
    PTM_PRESC_4   = 2'b01,
    PTM_PRESC_16  = 2'b10,
    PTM_PRESC_16B = 2'b11
  } ptm_presc_e;

  typedef logic [7:0] ptm_byte_t;

endpackage

// File: ptm_prescaler.sv
// Purpose: Instruction clock divider and selectable prescaler
// Assumes: hclk is the oscillator clock
// Notes:   One tick per four oscillator clocks times the ratio
`timescale 1ns/100ps
`include "ptm_map.svh"
module ptm_prescaler
  import ptm_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       clear,
  input  wire logic       run,
  input  wire ptm_presc_e presc_sel,
  // Result
  output logic            tick,
  output logic [5:0]      cnt
);

  logic [5:0] term;

  // Terminal count per ratio
  always_comb begin
    case (presc_sel)
      PTM_PRESC_1: term = `PTM_PRE_TERM_1;
      PTM_PRESC_4: term = `PTM_PRE_TERM_4;
      default:     term = `PTM_PRE_TERM_16;
    endcase
  end

  // Divider counter, cleared on request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 6'h00;
    end else if (clear) begin
      cnt <= 6'h00;
    end else if (run) begin
      cnt <= (cnt == term) ? 6'h00 : cnt + 6'h01;
    end
  end

  assign tick = run && (cnt == term);

endmodule

// File: period_timer_8bit_test.sv
// Purpose: Self-checking bench for the period timer
// Assumes: Zero wait state slave; byte address is four times the index
// Notes:   Reads are noted in a queue and checked by a monitor process
`timescale 1ns/100ps
`include "ptm_map.svh"
module period_timer_8bit_test;
  import ptm_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, rd_ph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, ssp_match, irq, cpu_irq;
  logic [7:0]  pwm_count, pwm_period, mx;
  int          err_count, tests_run, seed, n, k, d, p, i;
  logic [31:0] exp_q[$];
  string       name_q[$];

  assign hready = hreadyout;

  ptm_timer u_ptm_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_count(pwm_count),
    .pwm_period(pwm_period), .ssp_match(ssp_match), .irq(irq), .cpu_irq(cpu_irq)
  );

  // Clock at 20 MHz
  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    tests_run++;
    if (seen !== ex) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge hclk);
  endtask

  // One single transfer; a read notes its expected data first
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     input logic [31:0] ex, input string nm);
    int t;
    if (!wr) begin
      exp_q.push_back(ex);
      name_q.push_back(nm);
    end
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    t = 0;
    do begin @(posedge hclk); t++; end while (hready !== 1'b1 && t < 20);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); t++; end while (hready !== 1'b1 && t < 20);
    if (t >= 20) begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'b1, {22'h0, idx, 2'b00}, wd, 32'h0, "");
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] ex, input string nm);
    bus(1'b0, {22'h0, idx, 2'b00}, 32'h0, ex, nm);
  endtask

  // Cycles from now until the counter output next changes
  task automatic gap(output int g);
    logic [7:0] v;
    v = pwm_count;
    g = 0;
    do begin @(posedge hclk); g++; end while (pwm_count === v && g < 300);
    if (g >= 300) begin
      err_count++;
      end_sim();
    end
  endtask

  // Monitor: read data taken at the end of the data phase
  always @(posedge hclk) begin
    if (rd_ph && hready === 1'b1 && exp_q.size() > 0)
      check(name_q.pop_front(), hrdata, exp_q.pop_front());
    if (!hresetn) rd_ph <= 1'b0;
    else if (hready === 1'b1) rd_ph <= hsel && htrans[1] && !hwrite;
  end

  // Main sequence
  initial begin
    seed = 32'hd395;
    {hsel, hwrite} = 2'b00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    hresetn = 1'b0;
    cyc(3);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`PTM_IDX_CTRL, 32'h00, "ctrl");
    rd(`PTM_IDX_COUNT, 32'h00, "count");
    rd(`PTM_IDX_PERIOD, 32'hFF, "period");
    rd(`PTM_IDX_FLAGS, 32'h00, "flags");
    check("pwm_period", pwm_period, 8'hFF);
    wr(`PTM_IDX_CTRL, 32'hFB);
    rd(`PTM_IDX_CTRL, 32'h7B, "ctrl bit7");
    p = 1 + int'($unsigned($random(seed)) % 6);
    wr(`PTM_IDX_PERIOD, p);
    rd(`PTM_IDX_PERIOD, p, "period rw");
    check("pwm_period", pwm_period, p);
    wr(`PTM_IDX_COUNT, 32'h5A);
    rd(`PTM_IDX_COUNT, 32'h5A, "count rw");
    check("pwm_count", pwm_count, 8'h5A);
    wr(`PTM_IDX_CTRL, 32'h00);
    rd(`PTM_IDX_COUNT, 32'h5A, "count kept");
    $display("registers done");
    // Step spacing for every prescale code
    wr(`PTM_IDX_PERIOD, 32'hFF);
    for (k = 0; k < 4; k++) begin
      wr(`PTM_IDX_COUNT, 32'h00);
      wr(`PTM_IDX_CTRL, 32'h04 | k);
      gap(d);
      gap(d);
      check("step gap", d, (k == 0) ? 4 : (k == 1) ? 16 : 64);
      gap(d);
      check("stepping", d, (k == 0) ? 4 : (k == 1) ? 16 : 64);
    end
    // Counter or control write restarts the prescaler at a random phase
    for (i = 0; i < 2; i++) begin
      cyc(int'($unsigned($random(seed)) % 64));
      if (i == 0) wr(`PTM_IDX_COUNT, 32'h10);
      else wr(`PTM_IDX_CTRL, 32'h06);
      cyc(2);
      gap(d);
      check("restart", (d >= 60 && d <= 64), 1'b1);
    end
    wr(`PTM_IDX_CTRL, 32'h00);
    mx = pwm_count;
    cyc(300);
    check("stopped", pwm_count, mx);
    $display("prescaler done");
    // Postscale ratios, wrap and serial match pulses
    wr(`PTM_IDX_PERIOD, p);
    wr(`PTM_IDX_ENABLES, 32'h02);
    wr(`PTM_IDX_GATES, 32'h03);
    for (k = 0; k < 16; k++) begin
      wr(`PTM_IDX_CTRL, 32'h00);
      wr(`PTM_IDX_FLAGS, 32'h00);
      wr(`PTM_IDX_COUNT, 32'h00);
      wr(`PTM_IDX_CTRL, (k << 3) | 32'h04);
      n = 0;
      mx = 8'h00;
      for (d = 0; d < 1000 && cpu_irq !== 1'b1; d++) begin
        @(posedge hclk);
        if (ssp_match === 1'b1) n++;
        if (pwm_count > mx) mx = pwm_count;
      end
      if (d >= 1000) begin
        err_count++;
        end_sim();
      end
      check("match count", n, k + 1);
      check("peak count", mx, p);
      rd(`PTM_IDX_FLAGS, 32'h02, "flag set");
    end
    wr(`PTM_IDX_CTRL, 32'h00);
    $display("postscaler done");
    // Interrupt request only with flag, enable and both gates
    for (i = 0; i < 8; i++) begin
      wr(`PTM_IDX_ENABLES, {30'h0, i[0], 1'b0});
      wr(`PTM_IDX_GATES, {30'h0, i[2:1]});
      cyc(2);
      check("cpu_irq", cpu_irq, i == 7);
    end
    rd(`PTM_IDX_FLAGS, 32'h02, "flag held");
    wr(`PTM_IDX_FLAGS, 32'h00);
    rd(`PTM_IDX_FLAGS, 32'h00, "flag cleared");
    cyc(2);
    check("cpu_irq off", cpu_irq, 1'b0);
    // Sticky status, mask and read-to-clear
    wr(`PTM_IDX_MASK, 32'h00);
    cyc(2);
    check("irq masked", irq, 1'b0);
    wr(`PTM_IDX_MASK, 32'h03);
    cyc(2);
    check("irq", irq, 1'b1);
    rd(`PTM_IDX_STATUS, 32'h03, "status");
    cyc(2);
    check("irq cleared", irq, 1'b0);
    rd(`PTM_IDX_STATUS, 32'h00, "status clear");
    $display("interrupts done");
    // Unmapped places and a second reset
    wr(`PTM_IDX_COUNT, 32'h3C);
    bus(1'b1, 32'h0000_0444, 32'hEE, 32'h0, "");
    bus(1'b0, 32'h0000_03FC, 32'h0, 32'h0, "unmapped");
    rd(`PTM_IDX_COUNT, 32'h3C, "count safe");
    wr(`PTM_IDX_PERIOD, 32'h10);
    wr(`PTM_IDX_CTRL, 32'h7F);
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`PTM_IDX_PERIOD, 32'hFF, "period reset");
    rd(`PTM_IDX_COUNT, 32'h00, "count reset");
    rd(`PTM_IDX_CTRL, 32'h00, "ctrl reset");
    check("hresp", hresp, 1'b0);
    $display("reset done");
    end_sim();
  end
endmodule
